// ### hdl/gpab_top.sv
// port A and port B pin control with an APB register slave
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "gpab_map.svh"

// Notes on behaviour
// - both ports: eight pins, latch and direction
// - port A direction 1 drives, 0 input
// - port B direction 1 drives, 0 input
// - reset clears port A direction bits
// - reset keeps both data latches
// - data read returns latch for output pins
// - data read returns pin level for inputs
// - data writes update the latch only when the lane 0 strobe (PSTRB[0]) is set
// - input pin write touches only the latch
// - pullup on when enabled and input
// - output direction forces pullup off
// - key enable routes port A pin to keys
// - selected analog channel overrides port B pin
// - unselected port B pins stay digital
// - reset clears port B direction bits
module gpab_top #(
    parameter int PORT_W = 8,
    parameter int ADDR_W = 5,
    parameter int ADCH_W = 5
) (
    input wire logic CLOCK, // system clock
    input wire logic RST_N, // synchronous reset, active low
    input wire logic CE, // clock enable, freezes all state
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [ADDR_W-1:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    input wire logic [3:0] PSTRB, // apb byte strobes
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error
    input wire logic [PORT_W-1:0] PA_PIN_IN, // port A pin levels
    output logic [PORT_W-1:0] PA_PIN_OUT, // port A drive levels
    output logic [PORT_W-1:0] PA_PIN_OE, // port A driver enables
    output logic [PORT_W-1:0] PA_PULLUP_ON, // port A pullup enables
    input wire logic [PORT_W-1:0] PB_PIN_IN, // port B pin levels
    output logic [PORT_W-1:0] PB_PIN_OUT, // port B drive levels
    output logic [PORT_W-1:0] PB_PIN_OE, // port B driver enables
    output logic [PORT_W-1:0] PB_ANALOG_ON, // port B pins given to converter
    input wire logic [PORT_W-1:0] KEY_IRQ_ENABLES, // key interrupt enables
    input wire logic [ADCH_W-1:0] ANALOG_CHANNEL_SELECT, // converter channel
    output logic [PORT_W-1:0] KEY_INPUTS // gated port A levels to key unit
);

    typedef struct packed {
        logic [PORT_W-1:0] a_latch;
        logic [PORT_W-1:0] b_latch;
        logic [PORT_W-1:0] a_dir;
        logic [PORT_W-1:0] b_dir;
        logic [PORT_W-1:0] a_pu;
        logic [PORT_W-1:0] analog;
        logic [PORT_W-1:0] keys;
        gpab_pkg::gpab_apb_rsp_t rsp;
    } gpab_top_state_t;

    gpab_top_state_t state_reg;
    gpab_top_state_t state_next;
    gpab_pkg::gpab_apb_req_t req;

    logic [PORT_W-1:0] a_level;
    logic [PORT_W-1:0] b_level;
    logic [PORT_W-1:0] a_rd;
    logic [PORT_W-1:0] b_rd;
    logic [`GPAB_IDX_W-1:0] idx;
    logic aligned;
    logic access;
    logic first_access;
    logic commit;

    generate
        if (PORT_W < 1 || PORT_W > `GPAB_MAX_PORT_W) begin : g_bad_port
            $error("gpab_top: PORT_W out of range");
        end
        if (ADCH_W < 1 || ADCH_W > `GPAB_MAX_ADCH_W) begin : g_bad_adch
            $error("gpab_top: ADCH_W out of range");
        end
        if (ADDR_W < `GPAB_IDX_W + `GPAB_ALIGN_W || ADDR_W > 32) begin : g_bad_addr
            $error("gpab_top: ADDR_W too small for the register map");
        end
    endgenerate

    // index of a register that exists
    function automatic logic is_mapped(input logic [`GPAB_IDX_W-1:0] i);
        case (i)
            `GPAB_IDX_A_DATA, `GPAB_IDX_B_DATA, `GPAB_IDX_A_DIR, `GPAB_IDX_B_DIR,
            `GPAB_IDX_A_PU, `GPAB_IDX_LEVELS, `GPAB_IDX_JOINS: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // one-hot pin mask of the converter channel, empty when beyond the port
    function automatic logic [PORT_W-1:0] channel_mask(input logic [ADCH_W-1:0] sel);
        logic [PORT_W-1:0] m;
        m = '0;
        for (int k = 0; k < PORT_W; k++) begin
            if (32'(sel) == k) begin
                m[k] = 1'b1;
            end
        end
        channel_mask = m;
    endfunction : channel_mask

    // place a port-wide field into a word
    function automatic logic [31:0] field(input logic [PORT_W-1:0] v, input int lsb);
        field = 32'(v) << lsb;
    endfunction : field

    always_comb begin
        req.sel = PSEL;
        req.enable = PENABLE;
        req.write = PWRITE;
        req.addr = 32'(PADDR);
        req.wdata = PWDATA;
        req.strb = PSTRB;
    end

    assign idx = req.addr[`GPAB_ALIGN_W +: `GPAB_IDX_W];
    assign aligned = (req.addr[`GPAB_ALIGN_W-1:0] == `GPAB_ALIGN_OK)
        && ((req.addr >> (`GPAB_ALIGN_W + `GPAB_IDX_W)) == 32'h0000_0000);
    assign access = req.sel & req.enable;
    // first access cycle prepares the answer, ready follows one edge later
    assign first_access = access & ~state_reg.rsp.ready;
    // writes land on the edge where ready is sampled high
    assign commit = access & state_reg.rsp.ready & req.write & aligned & is_mapped(idx)
        & req.strb[`GPAB_LANE];

    always_comb begin
        state_next = state_reg;
        state_next.rsp.ready = first_access;
        state_next.rsp.slverr = first_access & ~(aligned & is_mapped(idx));
        if (first_access) begin
            state_next.rsp.rdata = 32'h0000_0000;
            if (aligned && !req.write) begin
                case (idx)
                    `GPAB_IDX_A_DATA: state_next.rsp.rdata = field(a_rd, 0);
                    `GPAB_IDX_B_DATA: state_next.rsp.rdata = field(b_rd, 0);
                    `GPAB_IDX_A_DIR: state_next.rsp.rdata = field(state_reg.a_dir, 0);
                    `GPAB_IDX_B_DIR: state_next.rsp.rdata = field(state_reg.b_dir, 0);
                    `GPAB_IDX_A_PU: state_next.rsp.rdata = field(state_reg.a_pu, 0);
                    `GPAB_IDX_LEVELS: state_next.rsp.rdata = field(a_level, `GPAB_LEVELS_A_LSB)
                        | field(b_level, `GPAB_LEVELS_B_LSB);
                    `GPAB_IDX_JOINS: state_next.rsp.rdata = field(state_reg.keys, `GPAB_JOINS_KEY_LSB)
                        | field(state_reg.analog, `GPAB_JOINS_ADC_LSB);
                    default: state_next.rsp.rdata = 32'h0000_0000;
                endcase
            end
        end
        if (commit) begin
            case (idx)
                `GPAB_IDX_A_DATA: state_next.a_latch = req.wdata[PORT_W-1:0];
                `GPAB_IDX_B_DATA: state_next.b_latch = req.wdata[PORT_W-1:0];
                `GPAB_IDX_A_DIR: state_next.a_dir = req.wdata[PORT_W-1:0];
                `GPAB_IDX_B_DIR: state_next.b_dir = req.wdata[PORT_W-1:0];
                `GPAB_IDX_A_PU: state_next.a_pu = req.wdata[PORT_W-1:0];
                default: state_next.a_latch = state_reg.a_latch;
            endcase
        end
        state_next.analog = channel_mask(ANALOG_CHANNEL_SELECT);
        state_next.keys = KEY_IRQ_ENABLES & a_level;
        if (!RST_N) begin
            state_next.a_dir = {PORT_W{`GPAB_DIR_RST}};
            state_next.b_dir = {PORT_W{`GPAB_DIR_RST}};
            state_next.a_pu = {PORT_W{`GPAB_PU_RST}};
            state_next.analog = {PORT_W{`GPAB_PIN_RST}};
            state_next.keys = {PORT_W{`GPAB_PIN_RST}};
            state_next.rsp = '{ready: 1'b0, slverr: 1'b0, rdata: 32'h0000_0000};
            state_next.a_latch = state_reg.a_latch;
            state_next.b_latch = state_reg.b_latch;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (CE) begin
            state_reg <= state_next;
        end
    end

    gpab_port #(
        .WIDTH(PORT_W)
    ) u_port_a (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .CE(CE),
        .pin_in(PA_PIN_IN),
        .latch(state_reg.a_latch),
        .dir(state_reg.a_dir),
        .pu_en(state_reg.a_pu),
        .analog({PORT_W{`GPAB_PIN_RST}}),
        .pin_out(PA_PIN_OUT),
        .pin_oe(PA_PIN_OE),
        .pull_on(PA_PULLUP_ON),
        .level(a_level),
        .rd(a_rd)
    );

    // port B has no pullups
    gpab_port #(
        .WIDTH(PORT_W)
    ) u_port_b (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .CE(CE),
        .pin_in(PB_PIN_IN),
        .latch(state_reg.b_latch),
        .dir(state_reg.b_dir),
        .pu_en({PORT_W{`GPAB_PU_RST}}),
        .analog(state_reg.analog),
        .pin_out(PB_PIN_OUT),
        .pin_oe(PB_PIN_OE),
        .pull_on(),
        .level(b_level),
        .rd(b_rd)
    );

    assign PRDATA = state_reg.rsp.rdata;
    assign PREADY = state_reg.rsp.ready;
    assign PSLVERR = state_reg.rsp.slverr;
    assign PB_ANALOG_ON = state_reg.analog;
    assign KEY_INPUTS = state_reg.keys;

endmodule : gpab_top

`default_nettype wire

// ### hdl/gpab_map.svh
// register indices, field positions and reset values of the port A/B block
`ifndef GPAB_MAP_SVH
`define GPAB_MAP_SVH

// register indices; byte address is four times the index
`define GPAB_IDX_W 3
`define GPAB_IDX_A_DATA 3'h0
`define GPAB_IDX_B_DATA 3'h1
`define GPAB_IDX_A_DIR 3'h2
`define GPAB_IDX_B_DIR 3'h3
`define GPAB_IDX_A_PU 3'h4
`define GPAB_IDX_LEVELS 3'h5
`define GPAB_IDX_JOINS 3'h6

// low address bits that must be zero for a word access
`define GPAB_ALIGN_W 2
`define GPAB_ALIGN_OK 2'h0

// byte lane that carries every writable register
`define GPAB_LANE 0

// field positions inside the read-only words
`define GPAB_LEVELS_A_LSB 0
`define GPAB_LEVELS_B_LSB 8
`define GPAB_JOINS_KEY_LSB 0
`define GPAB_JOINS_ADC_LSB 8

// reset values, one bit replicated over the port width
`define GPAB_DIR_RST 1'b0
`define GPAB_PU_RST 1'b0
`define GPAB_PIN_RST 1'b0

// width limits the register layout can carry
`define GPAB_MAX_PORT_W 8
`define GPAB_MAX_ADCH_W 8

`endif

// ### hdl/gpab_pkg.sv
// shared types of the port A/B block
package gpab_pkg;

    // one APB request as seen by the slave
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] strb;
    } gpab_apb_req_t;

    // one APB answer
    typedef struct packed {
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } gpab_apb_rsp_t;

endpackage : gpab_pkg

// ### hdl/gpab_port.sv
// one bidirectional pin port: synchroniser, drivers, pullups and read view
`timescale 1ns/1ps
`default_nettype none
`include "gpab_map.svh"

module gpab_port #(
    parameter int WIDTH = 8
) (
    input wire logic CLOCK, // system clock
    input wire logic RST_N, // synchronous reset
    input wire logic CE, // clock enable
    input wire logic [WIDTH-1:0] pin_in, // raw pin levels
    input wire logic [WIDTH-1:0] latch, // data latch
    input wire logic [WIDTH-1:0] dir, // 1 = output
    input wire logic [WIDTH-1:0] pu_en, // pullup enables
    input wire logic [WIDTH-1:0] analog, // pins taken by the converter
    output logic [WIDTH-1:0] pin_out, // driven level
    output logic [WIDTH-1:0] pin_oe, // driver on
    output logic [WIDTH-1:0] pull_on, // pullup on
    output logic [WIDTH-1:0] level, // synchronised pin level
    output logic [WIDTH-1:0] rd // value a data read returns
);

    typedef struct packed {
        logic [WIDTH-1:0] sync1;
        logic [WIDTH-1:0] level;
        logic [WIDTH-1:0] out;
        logic [WIDTH-1:0] oe;
        logic [WIDTH-1:0] pull;
        logic [WIDTH-1:0] rd;
    } gpab_port_state_t;

    gpab_port_state_t state_reg;
    gpab_port_state_t state_next;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("gpab_port: WIDTH must be at least 1");
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        state_next.sync1 = pin_in;
        state_next.level = state_reg.sync1;
        state_next.out = latch;
        state_next.oe = dir & ~analog;
        state_next.pull = pu_en & ~dir & ~analog;
        state_next.rd = (dir & latch) | (~dir & state_reg.level);
        if (!RST_N) begin
            state_next = '{
                sync1: {WIDTH{`GPAB_PIN_RST}},
                level: {WIDTH{`GPAB_PIN_RST}},
                out: {WIDTH{`GPAB_PIN_RST}},
                oe: {WIDTH{`GPAB_DIR_RST}},
                pull: {WIDTH{`GPAB_PU_RST}},
                rd: {WIDTH{`GPAB_PIN_RST}}
            };
        end
    end

    always_ff @(posedge CLOCK) begin
        if (CE) begin
            state_reg <= state_next;
        end
    end

    assign pin_out = state_reg.out;
    assign pin_oe = state_reg.oe;
    assign pull_on = state_reg.pull;
    assign level = state_reg.level;
    assign rd = state_reg.rd;

endmodule : gpab_port

`default_nettype wire

// ### tb/gpab_sva.sv
// assertion checker for the port A/B block
`timescale 1ns/1ps
`default_nettype none
module gpab_sva #(
    parameter int PORT_W = 8,
    parameter int ADDR_W = 5,
    parameter int ADCH_W = 5
) (
    input wire logic CLOCK, // clock
    input wire logic RST_N, // reset
    input wire logic PSEL, // apb
    input wire logic PENABLE, // apb
    input wire logic PWRITE, // apb
    input wire logic [ADDR_W-1:0] PADDR, // apb
    input wire logic [31:0] PWDATA, // apb
    input wire logic [3:0] PSTRB, // apb
    input wire logic PREADY, // apb
    input wire logic PSLVERR, // apb
    input wire logic [PORT_W-1:0] PA_PIN_IN, // pins
    input wire logic [PORT_W-1:0] PA_PIN_OE, // pins
    input wire logic [PORT_W-1:0] PA_PULLUP_ON, // pins
    input wire logic [PORT_W-1:0] PB_PIN_OE, // pins
    input wire logic [PORT_W-1:0] PB_ANALOG_ON, // pins
    input wire logic [PORT_W-1:0] KEY_IRQ_ENABLES, // joins
    input wire logic [ADCH_W-1:0] ANALOG_CHANNEL_SELECT, // joins
    input wire logic [PORT_W-1:0] KEY_INPUTS // joins
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    property p_oe_a;
        PREADY && PWRITE && PADDR == 5'h08 && PSTRB[0] |-> ##2 PA_PIN_OE == $past(PWDATA[7:0], 2);
    endproperty
    property p_rst;
        disable iff (1'b0) !RST_N |=> PA_PIN_OE == 8'h00 && PB_PIN_OE == 8'h00 && !PREADY;
    endproperty
    property p_pull;
        (PA_PULLUP_ON & PA_PIN_OE) == 8'h00;
    endproperty
    property p_analog;
        ANALOG_CHANNEL_SELECT < 5'h08 |=> PB_ANALOG_ON == (8'h01 << $past(ANALOG_CHANNEL_SELECT));
    endproperty
    property p_key;
        1'b1 |=> (KEY_INPUTS & ~$past(KEY_IRQ_ENABLES)) == 8'h00;
    endproperty
    property p_sync;
        (KEY_IRQ_ENABLES == 8'hFF && $stable(PA_PIN_IN)) [*4] |-> KEY_INPUTS == PA_PIN_IN;
    endproperty
    property p_ready;
        $rose(PSEL && PENABLE) |-> !PREADY ##1 PREADY ##1 !PREADY;
    endproperty
    property p_err;
        PREADY |-> PSLVERR == (PADDR > 5'h18 || PADDR[1:0] != 2'h0);
    endproperty
    a_oe_a: assert property (p_oe_a) else $error("port A drivers differ from direction write");
    a_rst: assert property (p_rst) else $error("drivers on after reset");
    a_pull: assert property (p_pull) else $error("pullup on an output pin");
    a_analog: assert property (p_analog) else $error("analog pin not taken");
    a_key: assert property (p_key) else $error("key input not gated");
    a_sync: assert property (p_sync) else $error("key level not passed");
    a_ready: assert property (p_ready) else $error("ready timing wrong");
    a_err: assert property (p_err) else $error("error flag wrong");
    c_err: cover property (PSLVERR);
    c_pull: cover property (PA_PULLUP_ON != 8'h00);
    c_key: cover property (KEY_INPUTS != 8'h00);
endmodule : gpab_sva
`default_nettype wire

// ### tb/gpab_ext.sv
// outside circuitry on one port: resolves each pin wire
`timescale 1ns/1ps
`default_nettype none
module gpab_ext (
    input wire logic clock, // system clock
    input wire logic [7:0] oe, // block drives
    input wire logic [7:0] out, // block level
    input wire logic [7:0] pu, // pullup on
    input wire logic [7:0] en, // outside drives
    input wire logic [7:0] val, // outside level
    output logic [7:0] pin // wire level
);
    logic [7:0] last = 8'h00;
    always_ff @(posedge clock) begin
        last <= pin;
    end
    // undriven pin toggles so no stale level passes
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin[i] = oe[i] ? out[i] : en[i] ? val[i] : pu[i] ? 1'b1 : ~last[i];
        end
    end
endmodule : gpab_ext
`default_nettype wire

// ### tb/tb_top.sv
// self-checking testbench of the port A/B block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic CE = 1'b1;
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR, e1;
    logic [4:0] PADDR = 5'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, r;
    logic [3:0] PSTRB = 4'hF;
    logic [7:0] PA_PIN_IN, PA_PIN_OUT, PA_PIN_OE, PA_PULLUP_ON, KEY_INPUTS;
    logic [7:0] PB_PIN_IN, PB_PIN_OUT, PB_PIN_OE, PB_ANALOG_ON, e8;
    logic [7:0] KEY_IRQ_ENABLES = 8'h00, a_en = 8'h00, a_val = 8'h00;
    logic [4:0] ANALOG_CHANNEL_SELECT = 5'h1F;
    int n_errors = 0, n_compared = 0;
    always #2 CLOCK = ~CLOCK;
    gpab_top uut (.CLOCK, .RST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY,
        .PSLVERR, .PA_PIN_IN, .PA_PIN_OUT, .PA_PIN_OE, .PA_PULLUP_ON, .PB_PIN_IN, .PB_PIN_OUT, .PB_PIN_OE,
        .PB_ANALOG_ON, .KEY_IRQ_ENABLES, .ANALOG_CHANNEL_SELECT, .KEY_INPUTS);
    gpab_ext ext_a (.clock(CLOCK), .oe(PA_PIN_OE), .out(PA_PIN_OUT), .pu(PA_PULLUP_ON), .en(a_en), .val(a_val),
        .pin(PA_PIN_IN));
    gpab_ext ext_b (.clock(CLOCK), .oe(PB_PIN_OE), .out(PB_PIN_OUT), .pu(8'h00), .en(8'h00), .val(8'h00),
        .pin(PB_PIN_IN));
    task automatic final_report();
        if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // one apb transfer, held until ready is seen
    task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        r = PRDATA;
        e1 = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask : rd
    task automatic t_reset();
        rd(5'h08, 32'h0);
        rd(5'h0C, 32'h0);
        rd(5'h10, 32'h0);
        apb(1'b0, 5'h1C, 32'h0);
        chk({31'h0, e1}, 32'h1);
        PSTRB <= 4'h0;
        wr(5'h08, 32'hFF);
        PSTRB <= 4'hF;
        rd(5'h08, 32'h0);
    endtask : t_reset
    task automatic t_out();
        a_en <= 8'hFF;
        wr(5'h00, 32'hA5);
        wr(5'h04, 32'h3C);
        wr(5'h08, 32'hFF);
        wr(5'h0C, 32'hFF);
        rd(5'h00, 32'hA5);
        rd(5'h04, 32'h3C);
        chk(PA_PIN_OUT, 8'hA5);
        chk(PB_PIN_OE, 8'hFF);
        chk(PB_PIN_OUT, 8'h3C);
    endtask : t_out
    task automatic t_mixed();
        wr(5'h08, 32'h0F);
        a_val <= 8'h96;
        repeat (6) @(posedge CLOCK);
        rd(5'h00, 32'h95);
        wr(5'h00, 32'h00);
        rd(5'h00, 32'h90);
        rd(5'h14, 32'h3C90);
        chk(PA_PIN_OUT, 8'h00);
    endtask : t_mixed
    task automatic t_pull();
        a_en <= 8'h00;
        wr(5'h08, 32'hF0);
        wr(5'h10, 32'hFF);
        repeat (6) @(posedge CLOCK);
        chk(PA_PULLUP_ON, 8'h0F);
        rd(5'h00, 32'h0F);
        wr(5'h10, 32'h00);
        repeat (3) @(posedge CLOCK);
        chk(PA_PULLUP_ON, 8'h00);
    endtask : t_pull
    task automatic t_keep();
        wr(5'h00, 32'h5A);
        wr(5'h04, 32'hC3);
        RST_N <= 1'b0;
        repeat (3) @(posedge CLOCK);
        RST_N <= 1'b1;
        rd(5'h08, 32'h0);
        rd(5'h0C, 32'h0);
        wr(5'h08, 32'hFF);
        wr(5'h0C, 32'hFF);
        rd(5'h00, 32'h5A);
        rd(5'h04, 32'hC3);
    endtask : t_keep
    task automatic t_key();
        wr(5'h08, 32'h00);
        a_en <= 8'hFF;
        a_val <= 8'h3C;
        KEY_IRQ_ENABLES <= 8'h0F;
        repeat (6) @(posedge CLOCK);
        chk(KEY_INPUTS, 8'h0C);
        rd(5'h18, 32'h0C);
        rd(5'h00, 32'h3C);
        KEY_IRQ_ENABLES <= 8'hFF;
        repeat (6) @(posedge CLOCK);
        chk(KEY_INPUTS, 8'h3C);
    endtask : t_key
    task automatic t_analog();
        for (int s = 0; s < 9; s++) begin
            ANALOG_CHANNEL_SELECT <= 5'(s);
            repeat (4) @(posedge CLOCK);
            e8 = (s < 8) ? 8'h01 << s : 8'h00;
            chk(PB_ANALOG_ON, e8);
            chk(PB_PIN_OE, e8 ^ 8'hFF);
        end
    endtask : t_analog
    initial begin
        repeat (10) @(posedge CLOCK);
        RST_N <= 1'b1;
        t_reset();
        t_out();
        t_mixed();
        t_pull();
        t_keep();
        t_key();
        t_analog();
        final_report();
    end
    initial begin
        repeat (3000) @(posedge CLOCK);
        n_errors++;
        final_report();
    end
endmodule : tb_top
bind gpab_top gpab_sva #(.PORT_W(PORT_W), .ADDR_W(ADDR_W), .ADCH_W(ADCH_W)) sva (.CLOCK, .RST_N, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PSTRB, .PREADY, .PSLVERR, .PA_PIN_IN, .PA_PIN_OE, .PA_PULLUP_ON, .PB_PIN_OE,
    .PB_ANALOG_ON, .KEY_IRQ_ENABLES, .ANALOG_CHANNEL_SELECT, .KEY_INPUTS);
`default_nettype wire
